//--- rtl/bank_ctl_if.sv
// Carrier between the command decoder and one bank tracker.
// Assumes strobes are one clock wide and only sent when already checked legal.
`timescale 1ns/1ps
`default_nettype none

interface bank_ctl_if;
	import sdram_cmd_pkg::*;
	logic act;
	logic rd;
	logic wr;
	logic ap;
	logic pre;
	logic stop;
	bank_state_e state;
	modport ctrl (output act, output rd, output wr, output ap, output pre, output stop, input state);
	modport bank (input act, input rd, input wr, input ap, input pre, input stop, output state);
endinterface : bank_ctl_if

`default_nettype wire

//--- rtl/bank_tracker.sv
// One bank's state and its timing counter.
// Assumes the decoder forwards only legal commands for this bank.
`timescale 1ns/1ps
`default_nettype none

module bank_tracker
	import sdram_cmd_pkg::*;
#(
	parameter int unsigned BURST_LEN = BURST_LEN_DEF
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Decoder side
	bank_ctl_if.bank port
);

	localparam logic [CNT_W-1:0] RP_LOAD = CNT_W'(RP_CYC - 1);
	localparam logic [CNT_W-1:0] RCD_LOAD = CNT_W'(RCD_CYC - 1);
	localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WR_CYC - 1);
	localparam logic [CNT_W-1:0] BL_LOAD = CNT_W'(BURST_LEN - 1);

	bank_state_e state;
	bank_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	wire logic cnt_done = (cnt == '0);
	wire logic [CNT_W-1:0] cnt_dec = cnt - CNT_W'(1);

	assign port.state = state;

	// Next state and counter load
	always_comb begin
		next_state = state;
		next_cnt = cnt_dec;
		case (state)
			B_IDLE: begin
				next_cnt = '0;
				if (port.act) begin
					next_state = B_ACTIVATING;
					next_cnt = RCD_LOAD;
				end
			end
			B_ACTIVATING: begin
				if (cnt_done) begin
					next_state = B_ACTIVE;
				end
			end
			B_ACTIVE, B_READ, B_WRITE: begin
				if (port.pre) begin
					next_state = B_PRECHARGING;
					next_cnt = RP_LOAD;
				end else if (port.rd) begin
					next_state = port.ap ? B_READ_AP : B_READ;
					next_cnt = BL_LOAD;
				end else if (port.wr) begin
					next_state = port.ap ? B_WRITE_AP : B_WRITE;
					next_cnt = BL_LOAD;
				end else if (state != B_ACTIVE && (port.stop || cnt_done)) begin
					next_state = B_ACTIVE;
				end else if (state == B_ACTIVE) begin
					next_cnt = '0;
				end
			end
			B_READ_AP: begin
				if (port.stop || cnt_done) begin
					next_state = B_PRECHARGING;
					next_cnt = RP_LOAD;
				end
			end
			B_WRITE_AP: begin
				if (port.stop || cnt_done) begin
					next_state = B_AP_RECOVER;
					next_cnt = WR_LOAD;
				end
			end
			B_AP_RECOVER: begin
				if (cnt_done) begin
					next_state = B_PRECHARGING;
					next_cnt = RP_LOAD;
				end
			end
			B_PRECHARGING: begin
				if (cnt_done) begin
					next_state = B_IDLE;
				end
			end
			default: begin
				next_state = B_IDLE;
				next_cnt = '0;
			end
		endcase
	end

	// State and counter registers
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= B_IDLE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

endmodule : bank_tracker

`default_nettype wire

//--- rtl/sdram_bank_cmd_fsm.sv
// Command legality and state tracking for a four-bank SDRAM, device side.
// Assumes commands are sampled on the rising edge of clk_in, synchronous to it.
//
// Operation
// - Check commands only when CKE high twice
// - Idle means precharged and tRP elapsed
// - Row active after tRCD, no burst
// - Read or write state until burst ends
// - Precharge enters precharging, idle after tRP
// - Activate enters activating, active after tRCD
// - Auto precharge access busy until tRP
// - Auto refresh occupies device for tRC
// - Mode register load occupies device tMRD
// - Precharge all occupies device for tRP
// - Precharge all needs every bank prechargeable
// - Burst terminate stops most recent burst
// - Row active accepts read, write, precharge
// - Read state accepts read, write, terminate, precharge
// - Write state accepts read, write, terminate, precharge
// - Inhibit and NOP continue current operation
// - Idle bank restricts no other bank
// - Busy-row bank leaves others free
// - Read or write elsewhere interrupts burst
// - Auto precharge forms share the tables
// - Refresh LLLH, mode load LLLL encodings
// - Interrupted auto precharge burst starts precharge
`timescale 1ns/1ps
`default_nettype none

module sdram_bank_cmd_fsm
	import sdram_cmd_pkg::*;
#(
	parameter int unsigned BURST_LEN = BURST_LEN_DEF
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Command pins
	input wire logic cke_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [BANK_W-1:0] ba_in,
	input wire logic ap_in,
	// Status
	output logic [NUM_BANKS*BSTATE_W-1:0] bank_state_out,
	output logic [3:0] dev_state_out,
	output logic accept_out,
	output logic illegal_out,
	output logic [2:0] cause_out
);

	localparam logic [CNT_W-1:0] RP_LOAD = CNT_W'(RP_CYC - 1);
	localparam logic [CNT_W-1:0] RC_LOAD = CNT_W'(RC_CYC - 1);
	localparam logic [CNT_W-1:0] MRD_LOAD = CNT_W'(MRD_CYC - 1);

	// Class masks over the one-hot bank state
	localparam logic [BSTATE_W-1:0] M_IDLE = B_IDLE;
	localparam logic [BSTATE_W-1:0] M_OPEN = B_ACTIVE | B_READ | B_WRITE;
	localparam logic [BSTATE_W-1:0] M_BURST = B_READ | B_WRITE;
	localparam logic [BSTATE_W-1:0] M_ANY_BURST = B_READ | B_WRITE | B_READ_AP | B_WRITE_AP;
	localparam logic [BSTATE_W-1:0] M_BUSY = B_ACTIVATING | B_PRECHARGING | B_READ_AP | B_WRITE_AP | B_AP_RECOVER;
	localparam logic [BSTATE_W-1:0] M_PRE_OK = B_IDLE | B_ACTIVE | B_READ | B_WRITE;

	// True when a bank state falls in a class
	function automatic logic in_class(input bank_state_e s, input logic [BSTATE_W-1:0] mask);
		in_class = |(s & mask);
	endfunction : in_class

	bank_ctl_if bif [NUM_BANKS] ();
	bank_state_e st [NUM_BANKS];

	logic cke_prev;
	dev_state_e dev_state;
	dev_state_e next_dev_state;
	logic [CNT_W-1:0] dev_cnt;
	logic [CNT_W-1:0] next_dev_cnt;
	logic [BANK_W-1:0] last_bank;
	logic [2:0] next_cause;

	// Command decode
	wire logic [3:0] cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
	wire logic eval = cke_prev & cke_in;
	wire logic is_act = eval && cmd == CMD_ACT;
	wire logic is_rd = eval && cmd == CMD_RD;
	wire logic is_wr = eval && cmd == CMD_WR;
	wire logic is_pre = eval && cmd == CMD_PRE;
	wire logic is_bst = eval && cmd == CMD_BST;
	wire logic is_ref = eval && cmd == CMD_REF;
	wire logic is_lmr = eval && cmd == CMD_LMR;
	wire logic is_rw = is_rd | is_wr;
	// Inhibit and NOP are not executable and leave every state alone
	wire logic is_exec = eval && !cs_n_in && cmd != CMD_NOP;

	// Whole-device views of the bank states
	logic [NUM_BANKS-1:0] idle_vec;
	logic [NUM_BANKS-1:0] pre_ok_vec;
	logic [NUM_BANKS-1:0] burst_vec;
	logic [NUM_BANKS-1:0] any_burst_vec;
	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++) begin : g_bank
			assign st[g] = bif[g].state;
			assign idle_vec[g] = in_class(st[g], M_IDLE);
			assign pre_ok_vec[g] = in_class(st[g], M_PRE_OK);
			assign burst_vec[g] = in_class(st[g], M_BURST);
			assign any_burst_vec[g] = in_class(st[g], M_ANY_BURST);
			assign bank_state_out[g*BSTATE_W +: BSTATE_W] = st[g];
		end
	endgenerate

	// Target bank classification
	wire bank_state_e tgt = st[ba_in];
	wire logic tgt_idle = in_class(tgt, M_IDLE);
	wire logic tgt_open = in_class(tgt, M_OPEN);
	wire logic tgt_busy = in_class(tgt, M_BUSY);
	wire logic tgt_pre_ok = in_class(tgt, M_PRE_OK);
	wire logic all_idle = &idle_vec;
	wire logic all_pre_ok = &pre_ok_vec;
	wire logic burst_open = burst_vec[last_bank];
	wire logic dev_free = (dev_state == DEV_NORMAL);

	// Per-command legality; other banks impose nothing on bank-specific commands
	wire logic ok_act = is_act & tgt_idle;
	wire logic ok_rw = is_rw & tgt_open;
	wire logic ok_pre = is_pre & (ap_in ? all_pre_ok : tgt_pre_ok);
	wire logic ok_bst = is_bst & burst_open;
	wire logic ok_ref = is_ref & all_idle;
	wire logic ok_lmr = is_lmr & all_idle;
	wire logic ok_any = ok_act | ok_rw | ok_pre | ok_bst | ok_ref | ok_lmr;
	wire logic go = dev_free & ok_any;
	wire logic refused = is_exec & ~go;

	// Accepted strobes
	wire logic go_act = go & ok_act;
	wire logic go_rw = go & ok_rw;
	wire logic go_pre = go & ok_pre;
	wire logic go_bst = go & ok_bst;
	wire logic go_ref = go & ok_ref;
	wire logic go_lmr = go & ok_lmr;
	wire logic go_pre_all = go_pre & ap_in;

	// Refusal cause, most specific first
	always_comb begin
		next_cause = CAUSE_NONE;
		if (refused) begin
			if (!dev_free) begin
				next_cause = CAUSE_DEV_BUSY;
			end else if ((is_ref | is_lmr) && !all_idle) begin
				next_cause = CAUSE_NOT_IDLE;
			end else if (is_bst) begin
				next_cause = CAUSE_NO_BURST;
			end else if (tgt_busy || (is_pre && ap_in && !all_pre_ok)) begin
				next_cause = CAUSE_BANK_BUSY;
			end else begin
				next_cause = CAUSE_BAD_STATE;
			end
		end
	end

	// Strobes toward each bank tracker
	generate
		for (g = 0; g < NUM_BANKS; g++) begin : g_ctl
			wire logic hit = (ba_in == BANK_W'(g));
			wire logic own_last = (last_bank == BANK_W'(g));
			assign bif[g].act = go_act & hit;
			assign bif[g].rd = go_rw & is_rd & hit;
			assign bif[g].wr = go_rw & is_wr & hit;
			assign bif[g].ap = ap_in;
			assign bif[g].pre = go_pre & (ap_in | hit);
			// Terminate, or interrupted by a burst started on another bank
			assign bif[g].stop = (go_bst & own_last) | (go_rw & !hit & any_burst_vec[g]);
		end
	endgenerate

	// Tracker instances
	generate
		for (g = 0; g < NUM_BANKS; g++) begin : g_trk
			bank_tracker #(
				.BURST_LEN(BURST_LEN)
			) u_trk (
				.clk_in(clk_in),
				.nrst_in(nrst_in),
				.port(bif[g].bank)
			);
		end
	endgenerate

	// Device-wide busy states
	always_comb begin
		next_dev_state = dev_state;
		next_dev_cnt = dev_cnt - CNT_W'(1);
		case (dev_state)
			DEV_NORMAL: begin
				next_dev_cnt = '0;
				if (go_ref) begin
					next_dev_state = DEV_REFRESH;
					next_dev_cnt = RC_LOAD;
				end else if (go_lmr) begin
					next_dev_state = DEV_MODE;
					next_dev_cnt = MRD_LOAD;
				end else if (go_pre_all) begin
					next_dev_state = DEV_PREALL;
					next_dev_cnt = RP_LOAD;
				end
			end
			DEV_REFRESH, DEV_MODE, DEV_PREALL: begin
				if (dev_cnt == '0) begin
					next_dev_state = DEV_NORMAL;
				end
			end
			default: begin
				next_dev_state = DEV_NORMAL;
				next_dev_cnt = '0;
			end
		endcase
	end

	// CKE history
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cke_prev <= 1'b0;
		end else begin
			cke_prev <= cke_in;
		end
	end

	// Device state and counter
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dev_state <= DEV_NORMAL;
			dev_cnt <= '0;
		end else begin
			dev_state <= next_dev_state;
			dev_cnt <= next_dev_cnt;
		end
	end

	// Bank of the most recent read or write burst
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			last_bank <= '0;
		end else if (go_rw) begin
			last_bank <= ba_in;
		end
	end

	// Registered status
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dev_state_out <= DEV_NORMAL;
			accept_out <= 1'b0;
			illegal_out <= 1'b0;
			cause_out <= CAUSE_NONE;
		end else begin
			dev_state_out <= next_dev_state;
			accept_out <= go;
			illegal_out <= refused;
			cause_out <= next_cause;
		end
	end

endmodule : sdram_bank_cmd_fsm

`default_nettype wire

//--- rtl/sdram_cmd_pkg.sv
// Shared constants for the SDRAM bank command tracker: command codes,
// bank and device state encodings, and timing counts.
// Assumes a single 40 MHz clock; every timing count is derived from a time in ns.
package sdram_cmd_pkg;

	// Clock and geometry
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned NUM_BANKS = 4;
	localparam int unsigned BANK_W = 2;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned BURST_LEN_DEF = 4;

	// Timing figures in ns
	localparam int unsigned T_RP_NS = 20;
	localparam int unsigned T_RCD_NS = 20;
	localparam int unsigned T_RC_NS = 70;
	localparam int unsigned T_MRD_NS = 50;
	localparam int unsigned T_WR_NS = 15;

	// Least time rounded up to whole clocks, never below one clock
	function automatic int unsigned cycles_up(input int unsigned ns);
		int unsigned c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		cycles_up = (c == 0) ? 1 : c;
	endfunction : cycles_up

	localparam int unsigned RP_CYC = cycles_up(T_RP_NS);
	localparam int unsigned RCD_CYC = cycles_up(T_RCD_NS);
	localparam int unsigned RC_CYC = cycles_up(T_RC_NS);
	localparam int unsigned MRD_CYC = cycles_up(T_MRD_NS);
	localparam int unsigned WR_CYC = cycles_up(T_WR_NS);

	// Command codes as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_LMR = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_BST = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;

	// Refusal causes
	localparam logic [2:0] CAUSE_NONE = 3'h0;
	localparam logic [2:0] CAUSE_DEV_BUSY = 3'h1;
	localparam logic [2:0] CAUSE_BANK_BUSY = 3'h2;
	localparam logic [2:0] CAUSE_BAD_STATE = 3'h3;
	localparam logic [2:0] CAUSE_NOT_IDLE = 3'h4;
	localparam logic [2:0] CAUSE_NO_BURST = 3'h5;

	// Per-bank state, one-hot
	typedef enum logic [8:0] {
		B_IDLE = 9'h001,
		B_ACTIVATING = 9'h002,
		B_ACTIVE = 9'h004,
		B_READ = 9'h008,
		B_WRITE = 9'h010,
		B_READ_AP = 9'h020,
		B_WRITE_AP = 9'h040,
		B_AP_RECOVER = 9'h080,
		B_PRECHARGING = 9'h100
	} bank_state_e;

	localparam int unsigned BSTATE_W = 9;

	// Whole-device state, one-hot
	typedef enum logic [3:0] {
		DEV_NORMAL = 4'h1,
		DEV_REFRESH = 4'h2,
		DEV_MODE = 4'h4,
		DEV_PREALL = 4'h8
	} dev_state_e;

endpackage : sdram_cmd_pkg

//--- verif/ctl_model.sv
// Controller model driving the SDRAM command pins.
// Assumes the bench calls put just after rising edges of the clock.
`timescale 1ns/1ps
`default_nettype none
module ctl_model
	import sdram_cmd_pkg::*;
(
	// Command pins
	output logic cke_out,
	output logic cs_n_out,
	output logic ras_n_out,
	output logic cas_n_out,
	output logic we_n_out,
	output logic [1:0] ba_out,
	output logic ap_out
);
	// Pins start as NOP with CKE low
	initial begin
		cke_out = 1'b0;
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} = CMD_NOP;
		ba_out = 2'h0;
		ap_out = 1'b0;
	end
	// One command; address lines toggle while a NOP stands
	task automatic put(input logic k, input logic [3:0] c, input logic [1:0] b, input logic a);
		cke_out <= k;
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} <= c;
		ba_out <= (c == CMD_NOP) ? ~ba_out : b;
		ap_out <= (c == CMD_NOP) ? ~ap_out : a;
	endtask : put
endmodule : ctl_model
`default_nettype wire

//--- verif/sdram_bank_cmd_fsm_sva.sv
// Port assertions for the bank command tracker.
// Assumes it is bound to the tracker top.
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_cmd_fsm_sva
	import sdram_cmd_pkg::*;
#(
	parameter int unsigned BURST_LEN = BURST_LEN_DEF
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Command pins
	input wire logic cke_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [BANK_W-1:0] ba_in,
	input wire logic ap_in,
	// Status
	input wire logic [NUM_BANKS*BSTATE_W-1:0] bank_state_out,
	input wire logic [3:0] dev_state_out,
	input wire logic accept_out,
	input wire logic illegal_out,
	input wire logic [2:0] cause_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	// Executable command on the pins
	wire logic exe = !cs_n_in && ({ras_n_in, cas_n_in, we_n_in} != 3'h7);
	// Device-wide busy spans
	sequence ref_run;
		(dev_state_out == DEV_REFRESH) [*3] ##1 (dev_state_out == DEV_NORMAL);
	endsequence
	sequence mode_run;
		(dev_state_out == DEV_MODE) [*2] ##1 (dev_state_out == DEV_NORMAL);
	endsequence
	a_cke_gate: assert property ((!cke_in || !$past(cke_in)) |=> !accept_out && !illegal_out)
		else $error("command seen without CKE high twice");
	a_nop_quiet: assert property (!exe |=> !accept_out && !illegal_out)
		else $error("NOP or inhibit answered");
	a_busy_refuse: assert property (exe && dev_state_out != DEV_NORMAL |=> !accept_out)
		else $error("command taken while device busy");
	a_ref_len: assert property ($rose(dev_state_out[1]) |-> ref_run)
		else $error("refresh span wrong");
	a_mode_len: assert property ($rose(dev_state_out[2]) |-> mode_run)
		else $error("mode load span wrong");
	a_preall_len: assert property ($rose(dev_state_out[3]) |=> dev_state_out == DEV_NORMAL && &bank_state_out[0+:1]
		&& bank_state_out == {4{9'h001}})
		else $error("precharge all span wrong");
	a_ref_idle: assert property ($rose(dev_state_out[1]) |-> $past(bank_state_out) == {4{9'h001}})
		else $error("refresh taken with a bank open");
	a_cause_pair: assert property (illegal_out == (cause_out != 3'h0))
		else $error("refusal cause does not match refusal pulse");
	// Per-bank timing of activating and precharging
	for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
		a_act_time: assert property ($rose(bank_state_out[g*9+1]) |=> bank_state_out[g*9+:9] == 9'h004)
			else $error("bank not active after activating");
		a_pre_time: assert property ($rose(bank_state_out[g*9+8]) |=> bank_state_out[g*9+:9] == 9'h001)
			else $error("bank not idle after precharging");
	end
endmodule : sdram_bank_cmd_fsm_sva
bind sdram_bank_cmd_fsm sdram_bank_cmd_fsm_sva #(.BURST_LEN(BURST_LEN)) u_sva (.clk_in, .nrst_in, .cke_in,
	.cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .ba_in, .ap_in, .bank_state_out, .dev_state_out, .accept_out,
	.illegal_out, .cause_out);
`default_nettype wire

//--- verif/tb_sdram_bank_command_state_machine.sv
// Self-checking bench for the bank command tracker.
// Assumes the controller model drives the pins and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_bank_command_state_machine;
	import sdram_cmd_pkg::*;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic cke, cs_n, ras_n, cas_n, we_n, ap, acc, ill;
	logic [1:0] ba, b, m;
	logic [35:0] bst;
	logic [3:0] dev, c;
	logic [2:0] cause;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	// Clock
	initial begin
		forever #12.5 clk_in = ~clk_in;
	end
	sdram_bank_cmd_fsm #(.BURST_LEN(BURST_LEN_DEF)) dut (.clk_in, .nrst_in, .cke_in(cke), .cs_n_in(cs_n),
		.ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .ba_in(ba), .ap_in(ap), .bank_state_out(bst),
		.dev_state_out(dev), .accept_out(acc), .illegal_out(ill), .cause_out(cause));
	ctl_model ctl (.cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
		.ba_out(ba), .ap_out(ap));
	// State a bank takes when a command is taken
	function automatic bank_state_e exp_st(input logic [3:0] k, input logic a);
		case (k)
			CMD_ACT: exp_st = B_ACTIVATING;
			CMD_RD: exp_st = a ? B_READ_AP : B_READ;
			CMD_WR: exp_st = a ? B_WRITE_AP : B_WRITE;
			default: exp_st = B_PRECHARGING;
		endcase
	endfunction : exp_st
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	// Command for one edge, then NOP; returns just after the sampling edge
	task automatic issue(input logic k, input logic [3:0] x, input logic [1:0] g, input logic a);
		@(posedge clk_in);
		ctl.put(k, x, g, a);
		@(posedge clk_in);
		ctl.put(k, CMD_NOP, g, a);
		#1;
	endtask : issue
	task automatic cmp(input string what, input logic [35:0] e, input logic [35:0] s);
		n_compared++;
		if (e !== s) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask : cmp
	task automatic chk_b(input logic [1:0] g, input bank_state_e e);
		cmp("bank state", e, bst[g*9+:9]);
	endtask : chk_b
	task automatic chk_d(input dev_state_e e);
		cmp("device state", e, dev);
	endtask : chk_d
	task automatic chk_r(input logic a, input logic i, input logic [2:0] k);
		cmp("response", {a, i, k}, {acc, ill, cause});
	endtask : chk_r
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	// Hang guard
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			mismatches++;
			results();
		end
	end
	initial begin
		void'($urandom(67095));
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		tick(1);
		b = 2'($urandom_range(3, 0));
		m = b + 2'($urandom_range(3, 1));
		for (int g = 0; g < 4; g++)
			chk_b(2'(g), B_IDLE);
		chk_d(DEV_NORMAL);
		$display("reset done");
		issue(0, CMD_ACT, b, 0);
		chk_r(0, 0, 0);
		issue(1, CMD_ACT, b, 0);
		chk_r(0, 0, 0);
		chk_b(b, B_IDLE);
		$display("cke done");
		issue(1, CMD_ACT, b, 0);
		chk_r(1, 0, 0);
		chk_b(b, B_ACTIVATING);
		tick(1);
		chk_b(b, B_ACTIVE);
		issue(1, CMD_BST, b, 0);
		chk_r(0, 1, CAUSE_NO_BURST);
		issue(1, CMD_RD, b, 0);
		tick(BURST_LEN_DEF - 1);
		chk_b(b, B_READ);
		tick(1);
		chk_b(b, B_ACTIVE);
		// Every access form, then close or auto close
		for (int k = 0; k < 4; k++) begin
			c = k[1] ? CMD_WR : CMD_RD;
			issue(1, c, b, k[0]);
			chk_r(1, 0, 0);
			chk_b(b, exp_st(c, k[0]));
			if (k[0]) begin
				tick(BURST_LEN_DEF);
				chk_b(b, k[1] ? B_AP_RECOVER : B_PRECHARGING);
				tick(k[1] ? 2 : 1);
			end else begin
				issue(1, CMD_PRE, b, 0);
				chk_b(b, B_PRECHARGING);
				tick(1);
			end
			chk_b(b, B_IDLE);
			issue(1, CMD_ACT, b, 0);
			tick(1);
		end
		$display("access done");
		issue(1, CMD_ACT, m, 0);
		chk_r(1, 0, 0);
		tick(1);
		issue(1, CMD_RD, b, 1);
		issue(1, CMD_RD, m, 0);
		chk_b(b, B_PRECHARGING);
		chk_b(m, B_READ);
		issue(1, CMD_WR, m, 0);
		chk_b(m, B_WRITE);
		issue(1, CMD_BST, b, 0);
		chk_b(m, B_ACTIVE);
		issue(1, CMD_PRE, b, 1);
		chk_r(1, 0, 0);
		chk_d(DEV_PREALL);
		tick(1);
		chk_d(DEV_NORMAL);
		chk_b(m, B_IDLE);
		$display("banks done");
		issue(1, CMD_ACT, b, 0);
		issue(1, CMD_REF, m, 0);
		chk_r(0, 1, CAUSE_NOT_IDLE);
		issue(1, CMD_ACT, b, 0);
		chk_r(0, 1, CAUSE_BAD_STATE);
		issue(1, CMD_RD, b, 1);
		issue(1, CMD_PRE, b, 0);
		chk_r(0, 1, CAUSE_BANK_BUSY);
		chk_b(b, B_READ_AP);
		tick(3);
		chk_b(b, B_IDLE);
		issue(1, CMD_RD, m, 0);
		chk_r(0, 1, CAUSE_BAD_STATE);
		issue(1, CMD_PRE, b, 0);
		chk_r(1, 0, 0);
		chk_b(b, B_IDLE);
		tick(1);
		issue(1, CMD_REF, m, 0);
		chk_d(DEV_REFRESH);
		issue(1, CMD_ACT, m, 0);
		chk_r(0, 1, CAUSE_DEV_BUSY);
		chk_d(DEV_REFRESH);
		tick(1);
		chk_d(DEV_NORMAL);
		issue(1, CMD_LMR, b, 0);
		chk_d(DEV_MODE);
		tick(1);
		chk_d(DEV_MODE);
		tick(1);
		chk_d(DEV_NORMAL);
		$display("device done");
		results();
	end
endmodule : tb_sdram_bank_command_state_machine
`default_nettype wire
